// ==== shared/pfsi_map.vh ====
`ifndef PFSI_MAP_VH
`define PFSI_MAP_VH

// Software register byte addresses on the plain register port.
`define PFSI_REG_FILTER      8'h00
`define PFSI_REG_BASE_LO     8'h04
`define PFSI_REG_BASE_HI     8'h08
`define PFSI_REG_LIMIT_LO    8'h0C
`define PFSI_REG_LIMIT_HI    8'h10
`define PFSI_REG_FEAT_LO     8'h14
`define PFSI_REG_FEAT_HI     8'h18
`define PFSI_REG_STATUS      8'h1C

// Filter word bit positions.
`define PFSI_SKIP_IND_BIT    27
`define PFSI_SKIP_COND_BIT   28
`define PFSI_SKIP_UNC_BIT    29
`define PFSI_INVERT_BIT      30
`define PFSI_ENABLE_BIT      31

// Save/restore bit 62 of the 64-bit enable mask, seen in the high word.
`define PFSI_FEAT_HI_BIT     30

// State image geometry: 128 bytes at byte 832 of the save region.
`define PFSI_IMG_BYTES       128
`define PFSI_IMG_OFFSET      832
`define PFSI_IMG_WORDS       32

// State image word indexes (byte offset divided by four).
`define PFSI_IMG_PTR_LO      5'h00
`define PFSI_IMG_PTR_HI      5'h01
`define PFSI_IMG_FLAGS       5'h02
`define PFSI_IMG_HEAD        5'h03
`define PFSI_IMG_RING_LO     5'h04
`define PFSI_IMG_RING_HI     5'h05
`define PFSI_IMG_SIZE        5'h06
`define PFSI_IMG_FILTER      5'h07
`define PFSI_IMG_REC_FIRST   5'h08
`define PFSI_IMG_REC_LAST    5'h0F
`define PFSI_IMG_CNT_FIRST   5'h10
`define PFSI_IMG_CNT_LAST    5'h15

// Field layouts.
`define PFSI_SIZE_BITS       28
`define PFSI_REC_LOG2        5
`define PFSI_REC_BYTES       32'h0000_0020
`define PFSI_ID_BITS         8

// Counter flag index of the branches-retired event.
`define PFSI_EVT_BRANCH      2

// Retired branch kinds.
`define PFSI_BR_UNCOND       2'h0
`define PFSI_BR_COND         2'h1
`define PFSI_BR_INDIRECT     2'h2

`endif

// ==== rtl/pfsi_top.v ====
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "pfsi_map.vh"

module pfsi_top #(
  parameter CNT_W = 32
) (
  // Clock and reset.
  input  wire              clk,
  input  wire              arst_n,
  // Software register port.
  input  wire [7:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  // Retirement stream from the core, same clock.
  input  wire              retire_valid,
  input  wire [63:0]       retire_addr,
  input  wire              retire_branch,
  input  wire [1:0]        retire_branch_kind,
  input  wire [3:0]        retire_event_hit,
  input  wire              addr_filter_capability,
  // State image port used by the save and restore instructions.
  input  wire              save_begin,
  input  wire              restore_begin,
  input  wire              restore_req_bit,
  input  wire              image_present_bit,
  input  wire [4:0]        img_addr,
  input  wire [31:0]       img_wdata,
  input  wire              img_wr,
  input  wire              img_rd,
  output reg  [31:0]       img_rdata,
  // Status towards the core.
  output reg               feature_available,
  output reg               saved_component_bit,
  output reg               profiling_on,
  output reg               record_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  reg  [31:0]      filter_word;          // Filter word, bits 31:27 live.
  reg  [63:0]      filter_window_base;   // Lowest eligible address.
  reg  [63:0]      filter_window_limit;  // Highest eligible address.
  reg  [63:0]      feature_enable_mask;  // Extended feature enable reg.
  reg  [63:0]      control_block_pointer;// Zero means profiling is off.
  reg  [15:0]      counter_active_flags; // Bit n marks event n active.
  reg  [31:0]      ring_head_offset;     // Byte offset of the next record.
  reg  [63:0]      ring_base_pointer;    // Linear base of the ring.
  reg  [27:0]      ring_size;            // Ring size in bytes.
  reg  [31:0]      pending_record_slot [0:7]; // Pending record words.
  reg  [CNT_W-1:0] event_counter [0:5];  // Counters for events 1 to 6.
  reg              restore_open;         // Image writes are accepted.
  reg  [31:0]      next_img_rdata;       // Image read mux.
  reg  [31:0]      next_reg_rdata;       // Register read mux.
  reg  [5:0]       count_hit;            // Per-event count this cycle.
  reg              in_window;            // Address inside the window.
  reg              addr_ok;              // Address passes the filter.
  reg              branch_ok;            // Branch survives suppression.
  reg              branch_event_on;      // Branches event is enabled.
  integer          i;                    // Loop index of the clocked logic.
  integer          k;                    // Loop index of the count logic.

  // The pending record and the counters each sit in a bank of at most
  // eight words, so the low three bits of the word index pick the slot.
  // The range tests around each use keep the two banks apart.
  wire [2:0] rec_idx = img_addr[2:0];
  wire [2:0] cnt_idx = img_addr[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Rounding to whole event records; used for size and head on restore.
  // The record size is a power of two, so rounding only clears low bits.

  function [31:0] pfsi_round_rec;
    input [31:0] val;
    begin
      pfsi_round_rec = {val[31:`PFSI_REC_LOG2], {`PFSI_REC_LOG2{1'b0}}};
    end
  endfunction

  wire [31:0] wr_size_round =
    pfsi_round_rec({4'h0, img_wdata[`PFSI_SIZE_BITS-1:0]});
  wire [31:0] wr_head_round = pfsi_round_rec(img_wdata);
  wire [31:0] size_ext = {4'h0, ring_size};

  ////////////////////////////////////////////////////////////////////////////
  // Eligibility of the retiring instruction.
  // Both checks are pure logic on this cycle's retirement inputs.

  // The window compare is a full 64-bit pair of comparators; keeping it
  // combinational means the filter sees the same cycle as the retirement.
  // Invert means strictly outside: both window ends are ineligible then.
  // A base above the limit makes the window empty, which software must
  // avoid when it wants the normal sense.
  always @* begin
    in_window = (retire_addr >= filter_window_base) &&
                (retire_addr <= filter_window_limit);
    addr_ok   = 1'b1;
    // Both bits count for nothing when the core lacks the capability.
    if (addr_filter_capability &&
        filter_word[`PFSI_ENABLE_BIT]) begin
      if (filter_word[`PFSI_INVERT_BIT]) begin
        addr_ok = !in_window;
      end else begin
        addr_ok = in_window;
      end
    end
  end

  // Branch suppression only matters while the branches event is active.
  // Event 2 is the branches-retired event; its flag is the enable.
  always @* begin
    branch_event_on = counter_active_flags[`PFSI_EVT_BRANCH];
    branch_ok       = retire_branch;
    if (branch_event_on) begin
      case (retire_branch_kind)
        `PFSI_BR_UNCOND: begin
          if (filter_word[`PFSI_SKIP_UNC_BIT]) begin
            branch_ok = 1'b0;
          end
        end
        `PFSI_BR_COND: begin
          if (filter_word[`PFSI_SKIP_COND_BIT]) begin
            branch_ok = 1'b0;
          end
        end
        `PFSI_BR_INDIRECT: begin
          if (filter_word[`PFSI_SKIP_IND_BIT]) begin
            branch_ok = 1'b0;
          end
        end
        default: begin
          branch_ok = retire_branch;
        end
      endcase
    end
  end

  // Which counters step this cycle; reporting follows counting.
  // Gating on the registered profiling_on costs one cycle after a pointer
  // load, which is harmless: a restore never overlaps retirement.
  // The loop has its own index so no variable has two driving processes.
  always @* begin
    count_hit = 6'h00;
    if (retire_valid && addr_ok && profiling_on) begin
      count_hit[0] = counter_active_flags[1];
      count_hit[1] = counter_active_flags[`PFSI_EVT_BRANCH] &&
                     branch_ok;
      for (k = 0; k < 4; k = k + 1) begin
        count_hit[k+2] = counter_active_flags[k+3] &&
                         retire_event_hit[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and restore of the state image.

  // Image writes and software writes share one process so each field has a
  // single driver; the image port wins if both touch the filter word.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filter_word           <= 32'h0000_0000;
      filter_window_base    <= 64'h0000_0000_0000_0000;
      filter_window_limit   <= 64'h0000_0000_0000_0000;
      feature_enable_mask   <= 64'h0000_0000_0000_0000;
      control_block_pointer <= 64'h0000_0000_0000_0000;
      counter_active_flags  <= 16'h0000;
      ring_head_offset      <= 32'h0000_0000;
      ring_base_pointer     <= 64'h0000_0000_0000_0000;
      ring_size             <= 28'h000_0000;
      restore_open          <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        pending_record_slot[i] <= 32'h0000_0000;
      end
      for (i = 0; i < 6; i = i + 1) begin
        event_counter[i] <= {CNT_W{1'b0}};
      end
    end else begin
      // Software register writes. The status word is read only, so a
      // write to it falls into the default and changes nothing.
      if (reg_wr) begin
        case (reg_addr)
          `PFSI_REG_FILTER:   filter_word <= reg_wdata;
          `PFSI_REG_BASE_LO:  filter_window_base[31:0] <= reg_wdata;
          `PFSI_REG_BASE_HI:  filter_window_base[63:32] <= reg_wdata;
          `PFSI_REG_LIMIT_LO: filter_window_limit[31:0] <= reg_wdata;
          `PFSI_REG_LIMIT_HI: filter_window_limit[63:32] <= reg_wdata;
          `PFSI_REG_FEAT_LO:  feature_enable_mask[31:0] <= reg_wdata;
          `PFSI_REG_FEAT_HI:  feature_enable_mask[63:32] <= reg_wdata;
          default: begin
            filter_word <= filter_word;
          end
        endcase
      end
      // Counters step down on every eligible event.
      for (i = 0; i < 6; i = i + 1) begin
        if (count_hit[i]) begin
          event_counter[i] <= event_counter[i] - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // A save closes any restore window.
      if (save_begin) begin
        restore_open <= 1'b0;
      end
      // Restore start: decide whether state is loaded, zeroed or kept.
      if (restore_begin) begin
        // Feature off or not requested: profiler state is left untouched,
        // only the write window closes so stale image writes are dropped.
        if (!feature_enable_mask[`PFSI_FEAT_HI_BIT + 32] ||
            !restore_req_bit) begin
          restore_open <= 1'b0;
        end else if (!image_present_bit) begin
          // No saved state: supplied values disable profiling.
          restore_open          <= 1'b0;
          control_block_pointer <= 64'h0000_0000_0000_0000;
          counter_active_flags  <= 16'h0000;
          ring_head_offset      <= 32'h0000_0000;
          ring_base_pointer     <= 64'h0000_0000_0000_0000;
          ring_size             <= 28'h000_0000;
          for (i = 0; i < 8; i = i + 1) begin
            pending_record_slot[i] <= 32'h0000_0000;
          end
        end else begin
          restore_open <= 1'b1;
        end
      end else if (restore_open && img_wr) begin
        case (img_addr)
          `PFSI_IMG_PTR_LO:
            control_block_pointer[31:0] <= img_wdata;
          `PFSI_IMG_PTR_HI:
            control_block_pointer[63:32] <= img_wdata;
          `PFSI_IMG_FLAGS: begin
            // Bit 0 and bits 15:7 stay clear; they are reserved.
            counter_active_flags <= {9'h000, img_wdata[6:1],
                                     1'b0};
          end
          `PFSI_IMG_HEAD: begin
            ring_head_offset <= wr_head_round;
          end
          `PFSI_IMG_RING_LO:
            ring_base_pointer[31:0] <= img_wdata;
          `PFSI_IMG_RING_HI:
            ring_base_pointer[63:32] <= img_wdata;
          `PFSI_IMG_SIZE:
            ring_size <= wr_size_round[`PFSI_SIZE_BITS-1:0];
          `PFSI_IMG_FILTER:
            filter_word <= img_wdata;
          default: begin
            if (img_addr >= `PFSI_IMG_REC_FIRST &&
                img_addr <= `PFSI_IMG_REC_LAST) begin
              pending_record_slot[rec_idx] <= img_wdata;
            end else if (img_addr >= `PFSI_IMG_CNT_FIRST &&
                         img_addr <= `PFSI_IMG_CNT_LAST) begin
              event_counter[cnt_idx] <= img_wdata[CNT_W-1:0];
            end
          end
        endcase
      end else if (restore_open &&
                   ring_head_offset > size_ext - `PFSI_REC_BYTES) begin
        // A head beyond the last whole record restarts at zero. It is
        // judged while the window stays open, so size and head may be
        // written in either order.
        ring_head_offset <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Save: image read mux. Values leave unchecked and unconverted.
  // Reserved words fall through to the zero default; flag bit 0 and flag
  // bits 15:7 are never stored, so they read zero as well.

  always @* begin
    next_img_rdata = 32'h0000_0000; // reserved words read zero
    case (img_addr)
      `PFSI_IMG_PTR_LO:  next_img_rdata = control_block_pointer[31:0];
      `PFSI_IMG_PTR_HI:  next_img_rdata = control_block_pointer[63:32];
      `PFSI_IMG_FLAGS:   next_img_rdata = {16'h0000,
                                           counter_active_flags};
      `PFSI_IMG_HEAD:    next_img_rdata = ring_head_offset;
      `PFSI_IMG_RING_LO: next_img_rdata = ring_base_pointer[31:0];
      `PFSI_IMG_RING_HI: next_img_rdata = ring_base_pointer[63:32];
      `PFSI_IMG_SIZE:    next_img_rdata = size_ext;
      `PFSI_IMG_FILTER:  next_img_rdata = filter_word;
      default: begin
        if (img_addr >= `PFSI_IMG_REC_FIRST &&
            img_addr <= `PFSI_IMG_REC_LAST) begin
          next_img_rdata = pending_record_slot[rec_idx];
        end else if (img_addr >= `PFSI_IMG_CNT_FIRST &&
                     img_addr <= `PFSI_IMG_CNT_LAST) begin
          next_img_rdata = event_counter[cnt_idx];
        end
      end
    endcase
  end

  // Register read mux; unmapped addresses read zero.
  always @* begin
    next_reg_rdata = 32'h0000_0000;
    case (reg_addr)
      `PFSI_REG_FILTER:   next_reg_rdata = filter_word;
      `PFSI_REG_BASE_LO:  next_reg_rdata = filter_window_base[31:0];
      `PFSI_REG_BASE_HI:  next_reg_rdata = filter_window_base[63:32];
      `PFSI_REG_LIMIT_LO: next_reg_rdata = filter_window_limit[31:0];
      `PFSI_REG_LIMIT_HI: next_reg_rdata = filter_window_limit[63:32];
      `PFSI_REG_FEAT_LO:  next_reg_rdata = feature_enable_mask[31:0];
      `PFSI_REG_FEAT_HI:  next_reg_rdata = feature_enable_mask[63:32];
      // Status packs the low flag byte with the live state bits.
      `PFSI_REG_STATUS:   next_reg_rdata = {16'h0000,
                                            counter_active_flags[7:0],
                                            4'h0, restore_open, record_pending,
                                            saved_component_bit,
                                            profiling_on};
      default:            next_reg_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flip-flops.

  // Read data stand one cycle after the strobe and are zero otherwise, so
  // a stale word can never be mistaken for an answer.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata           <= 32'h0000_0000;
      img_rdata           <= 32'h0000_0000;
      feature_available   <= 1'b0;
      saved_component_bit <= 1'b0;
      profiling_on        <= 1'b0;
      record_pending      <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? next_reg_rdata : 32'h0000_0000;
      img_rdata <= img_rd ? next_img_rdata : 32'h0000_0000;
      feature_available <=
        feature_enable_mask[`PFSI_FEAT_HI_BIT + 32];
      // The bitmap bit is latched only by a save and then holds, so the
      // core may read it from the cycle after the save_begin strobe onwards.
      if (save_begin) begin
        saved_component_bit <= (control_block_pointer !=
                                64'h0000_0000_0000_0000);
      end
      profiling_on <= (control_block_pointer !=
                       64'h0000_0000_0000_0000);
      record_pending <= (pending_record_slot[0][`PFSI_ID_BITS-1:0] !=
                         8'h00);
    end
  end

endmodule // pfsi_top

// ==== test/pfsi_chk.sv ====
`timescale 1ns/100ps
module pfsi_chk (
  // Clock and reset.
  input wire        clk,
  input wire        arst_n,
  // Register port.
  input wire [7:0]  reg_addr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  // Save and restore control.
  input wire        save_begin,
  input wire        restore_begin,
  input wire        restore_req_bit,
  input wire        image_present_bit,
  // Image read side.
  input wire [4:0]  img_addr,
  input wire        img_rd,
  input wire [31:0] img_rdata,
  // Status.
  input wire        feature_available,
  input wire        saved_component_bit,
  input wire        profiling_on,
  input wire        record_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // An image read of word a; its data stands in the following cycle.
  sequence s_rd(a);
    img_rd && img_addr == a;
  endsequence
  // A restore that finds no saved profiler state in the image.
  sequence s_empty;
    restore_begin && restore_req_bit && !image_present_bit
      && feature_available;
  endsequence
  AST_FEAT: assert property (reg_rd && reg_addr == 8'h18 |=>
    reg_rdata[30] == feature_available) else $error("feature bit mismatch");
  AST_IMG_IDLE: assert property (!img_rd |=> img_rdata == 32'h0)
    else $error("image data outside read slot");
  AST_RSVD: assert property (img_rd && img_addr >= 5'h16 |=>
    img_rdata == 32'h0) else $error("reserved word not zero");
  AST_FLAGS: assert property (s_rd(5'h02) |=>
    img_rdata[0] == 1'b0 && img_rdata[31:7] == 25'h0)
    else $error("reserved flag bits set");
  AST_SIZE: assert property (s_rd(5'h06) |=>
    img_rdata[31:28] == 4'h0 && img_rdata[4:0] == 5'h0)
    else $error("ring size not masked or rounded");
  AST_HEAD: assert property (s_rd(5'h03) |=> img_rdata[4:0] == 5'h0)
    else $error("head offset not rounded");
  AST_REC: assert property (s_rd(5'h08) |=>
    record_pending == (img_rdata[7:0] != 8'h0))
    else $error("pending flag disagrees with record");
  // Both outputs take the pointer test at the save edge, so they agree.
  AST_SAVE: assert property (save_begin |=>
    saved_component_bit == profiling_on)
    else $error("saved bitmap bit wrong");
  AST_SAVE_HOLD: assert property (!save_begin |=>
    $stable(saved_component_bit)) else $error("bitmap bit moved");
  AST_EMPTY: assert property (s_empty |=> ##1
    !profiling_on && !record_pending) else $error("empty restore kept state");
endmodule // pfsi_chk

// ==== test/pfsi_top_tb.sv ====
`timescale 1ns/100ps
`include "pfsi_map.vh"
module pfsi_top_tb;
  reg clk, arst_n, reg_wr, reg_rd, rv, rb, cap, sb, rsb, rq, ip, iwr, ird;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata, img_wdata;
  reg [63:0] ra;
  reg [1:0] rk;
  reg [3:0] eh;
  reg [4:0] img_addr;
  wire [31:0] reg_rdata, img_rdata;
  wire fa, scb, pon, rp;
  integer fails, compares;
  // The device under test; events 3 and 5 hit on every retirement.
  pfsi_top pfsi_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .retire_valid(rv), .retire_addr(ra),
    .retire_branch(rb), .retire_branch_kind(rk), .retire_event_hit(eh),
    .addr_filter_capability(cap), .save_begin(sb), .restore_begin(rsb),
    .restore_req_bit(rq), .image_present_bit(ip), .img_addr(img_addr),
    .img_wdata(img_wdata), .img_wr(iwr), .img_rd(ird), .img_rdata(img_rdata),
    .feature_available(fa), .saved_component_bit(scb), .profiling_on(pon),
    .record_pending(rp));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // Compare, count and report.
  task chk(input [63:0] got, input [63:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Register writes and reads; read data stand one cycle after the strobe.
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask
  // Image word writes and reads, as the restore and save steps use them.
  task iw(input [4:0] a, input [31:0] d);
    begin
      @(posedge clk);
      img_addr <= a;
      img_wdata <= d;
      iwr <= 1'b1;
      @(posedge clk);
      iwr <= 1'b0;
    end
  endtask
  task ir(input [4:0] a, input [31:0] e);
    begin
      @(posedge clk);
      img_addr <= a;
      ird <= 1'b1;
      @(posedge clk);
      ird <= 1'b0;
      #1 chk(img_rdata, e);
    end
  endtask
  // One retirement; kind only matters when it is a branch.
  task ret(input [63:0] a, input b, input [1:0] k);
    begin
      @(posedge clk);
      rv <= 1'b1;
      ra <= a;
      rb <= b;
      rk <= k;
      @(posedge clk);
      rv <= 1'b0;
    end
  endtask
  // Restore start with the requested bit set; p says whether state exists.
  task rs(input p);
    begin
      @(posedge clk);
      rsb <= 1'b1;
      rq <= 1'b1;
      ip <= p;
      @(posedge clk);
      rsb <= 1'b0;
    end
  endtask
  task sv;
    begin
      @(posedge clk);
      sb <= 1'b1;
      @(posedge clk);
      sb <= 1'b0;
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog; the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    fails = fails + 1;
    end_sim;
  end
  initial begin
    {clk, arst_n, reg_wr, reg_rd, rv, rb, sb, rsb, rq, ip, iwr, ird} = 0;
    cap = 1'b1;
    eh = 4'h5;
    {reg_addr, reg_wdata, img_wdata, ra, rk, img_addr} = 0;
    fails = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    wr(`PFSI_REG_FEAT_HI, 32'h4000_0000);
    wr(`PFSI_REG_BASE_LO, 32'h0000_1000);
    wr(`PFSI_REG_LIMIT_LO, 32'h0000_1FFF);
    rd(`PFSI_REG_FEAT_HI, 32'h4000_0000);
    chk(fa, 1'b1);
    // Size goes in before head so the head is judged against it.
    // Reserved image bits are written as zero, as software must.
    rs(1'b1);
    iw(5'h06, 32'h0000_0047);
    iw(5'h00, 32'h0000_1000);
    iw(5'h02, 32'h0000_007E);
    iw(5'h03, 32'h0000_0025);
    iw(5'h04, 32'h1234_5678);
    iw(5'h08, 32'h0000_0005);
    iw(5'h10, 32'h0000_0100);
    iw(5'h11, 32'h0000_0100);
    iw(5'h12, 32'h0000_0100);
    iw(5'h13, 32'h0000_0100);
    ir(5'h02, 32'h0000_007E);
    ir(5'h03, 32'h0000_0020);
    ir(5'h06, 32'h0000_0040);
    ir(5'h04, 32'h1234_5678);
    ir(5'h08, 32'h0000_0005);
    ir(5'h16, 32'h0000_0000);
    // A head past the last whole record of a 64-byte ring restarts at 0.
    iw(5'h03, 32'h0000_0060);
    ir(5'h03, 32'h0000_0000);
    chk({pon, rp}, 2'h3);
    rd(`PFSI_REG_STATUS, 32'h0000_7E0D);
    // Address filter off, inclusive window, inverted window, no capability.
    ret(64'h5000, 1'b0, 2'h0);
    ir(5'h10, 32'h0000_00FF);
    wr(`PFSI_REG_FILTER, 32'h8000_0000);
    ret(64'h1000, 1'b0, 2'h0);
    ret(64'h1FFF, 1'b0, 2'h0);
    ret(64'h2000, 1'b0, 2'h0);
    ir(5'h10, 32'h0000_00FD);
    wr(`PFSI_REG_FILTER, 32'hC000_0000);
    ret(64'h1000, 1'b0, 2'h0);
    ret(64'h0FFF, 1'b0, 2'h0);
    ir(5'h10, 32'h0000_00FC);
    @(posedge clk) cap <= 1'b0;
    ret(64'h1000, 1'b0, 2'h0);
    ir(5'h10, 32'h0000_00FB);
    @(posedge clk) cap <= 1'b1;
    // Invert alone must be ignored: an address inside the window counts.
    wr(`PFSI_REG_FILTER, 32'h4000_0000);
    ret(64'h1000, 1'b0, 2'h0);
    ir(5'h10, 32'h0000_00FA);
    // Branch suppression on the branch event counter.
    wr(`PFSI_REG_FILTER, 32'h2000_0000);
    ret(64'h5000, 1'b1, `PFSI_BR_UNCOND);
    ret(64'h5000, 1'b1, `PFSI_BR_COND);
    ir(5'h11, 32'h0000_00FF);
    wr(`PFSI_REG_FILTER, 32'h3800_0000);
    ret(64'h5000, 1'b1, `PFSI_BR_COND);
    ret(64'h5000, 1'b1, `PFSI_BR_INDIRECT);
    ret(64'h5000, 1'b1, `PFSI_BR_UNCOND);
    ir(5'h11, 32'h0000_00FF);
    ir(5'h10, 32'h0000_00F5);
    // Event 3 hit on every eligible retirement, event 4 never.
    ir(5'h12, 32'h0000_00F5);
    ir(5'h13, 32'h0000_0100);
    ir(5'h07, 32'h3800_0000);
    // Save with profiling on, then an empty restore and a second save.
    sv;
    chk(scb, 1'b1);
    rs(1'b0);
    repeat (2) @(posedge clk);
    #1 chk({pon, rp}, 2'h0);
    sv;
    chk(scb, 1'b0);
    ir(5'h07, 32'h3800_0000);
    end_sim;
  end
endmodule // pfsi_top_tb
bind pfsi_top pfsi_chk pfsi_chk_i (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .save_begin(save_begin), .restore_begin(restore_begin),
  .restore_req_bit(restore_req_bit), .image_present_bit(image_present_bit),
  .img_addr(img_addr), .img_rd(img_rd), .img_rdata(img_rdata),
  .feature_available(feature_available),
  .saved_component_bit(saved_component_bit),
  .profiling_on(profiling_on), .record_pending(record_pending));
